// [tb/sfd_core_sva.sv]
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module sfd_core_sva
  import sfd_pkg::*;
#(
  parameter bit DSP_VARIANT = 1'b0
)
(
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        instr_valid_in,
  input wire logic        priv_mode_in,
  input wire logic        instr_ready_out,
  input wire logic        busy_out,
  input wire logic        issue_out,
  input wire sfd_op_type  op_out,
  input wire sfd_src_type src_sel_out,
  input wire sfd_addr_type addr_mode_out,
  input wire logic        gpr_wr_out,
  input wire logic        addr_upd_out,
  input wire logic        mem_rd_out,
  input wire logic        mem_wr_out,
  input wire logic        fr_wr_out,
  input wire logic        trap_out,
  input wire logic [11:0] trap_cause_out,
  input wire logic [11:0] trap_vec_ofs_out,
  input wire logic [31:0] result_out,
  input wire logic        exc_priv_out,
  input wire logic        exc_illegal_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  // ==========================================================
  // Assertions
  AST_ACCEPT_ANSWER: assert property (instr_valid_in && instr_ready_out |=>
    issue_out || busy_out || exc_priv_out || exc_illegal_out)
    else $error("accepted instruction got no answer");
  AST_EXC_QUIET: assert property (exc_priv_out || exc_illegal_out |->
    !(issue_out || gpr_wr_out || addr_upd_out || mem_rd_out || mem_wr_out || trap_out))
    else $error("exception with side effect");
  AST_PRIV_USER: assert property (exc_priv_out |-> !$past(priv_mode_in))
    else $error("privilege fault in privileged mode");
  AST_TRAP_FIELDS: assert property (trap_out |->
    trap_cause_out == 12'h160 && trap_vec_ofs_out == 12'h100)
    else $error("trap cause or vector offset wrong");
  AST_TRAP_LEN: assert property (trap_out |-> busy_out[*6] ##1
    (!DSP_VARIANT || busy_out) ##1 (!DSP_VARIANT || busy_out))
    else $error("trap shorter than minimum");
  AST_LONG_FP: assert property (issue_out && op_out inside {OP_FP_QUOT, OP_FP_SQRT} |->
    busy_out[*8] ##1 busy_out[*5])
    else $error("long float op shorter than 13");
  AST_BANK_PUSH: assert property (issue_out && op_out == OP_CR_PUSH && src_sel_out == SRC_BANK
    |-> busy_out[*2])
    else $error("bank push shorter than 2");
  AST_PREDEC: assert property (addr_upd_out && addr_mode_out == AM_PREDEC |-> mem_wr_out)
    else $error("predecrement without write");
  AST_POSTINC: assert property (addr_upd_out && addr_mode_out == AM_POSTINC |-> mem_rd_out)
    else $error("postincrement without read");
  AST_FP_ONE: assert property (fr_wr_out && op_out == OP_FP_ONE |-> result_out == 32'h3F80_0000)
    else $error("load one constant wrong");

  // Main scenarios reached
  CV_TRAP: cover property (trap_out);
  CV_PRIV: cover property (exc_priv_out);
  CV_STALL: cover property (busy_out && !issue_out && !instr_ready_out);
endmodule

bind sfd_core sfd_core_sva #(.DSP_VARIANT(DSP_VARIANT)) sfd_core_sva_i (.sys_clk_in, .srst_in,
  .instr_valid_in, .priv_mode_in, .instr_ready_out, .busy_out, .issue_out, .op_out,
  .src_sel_out, .addr_mode_out, .gpr_wr_out, .addr_upd_out, .mem_rd_out, .mem_wr_out,
  .fr_wr_out, .trap_out, .trap_cause_out, .trap_vec_ofs_out, .result_out, .exc_priv_out,
  .exc_illegal_out);

// [tb/sfd_core_tb.sv]
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module sfd_core_tb;
  import sfd_pkg::*;
  logic        sys_clk, srst, vld, prv, fc, ldv;
  logic [15:0] ins;
  logic [3:0]  ldi;
  logic [31:0] frn, frm, xf, res;
  logic        rdy, busy, iss, gw, au, mr, mw, tw, tv, trp, ep, ei, fw, xw, fs;
  logic [9:0]  tcode;
  logic [2:0]  bks;
  logic [3:0]  dix, six;
  int          num_errors = 0;
  int          checks = 0;

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  sfd_fpr_model sfd_fpr_model_i (.instr_in(ins), .fr_n_out(frn), .fr_m_out(frm), .xfer_out(xf));
  sfd_core sfd_core_i (.sys_clk_in(sys_clk), .srst_in(srst), .instr_valid_in(vld),
    .instr_in(ins), .priv_mode_in(prv), .fetch_contend_in(fc), .load_dest_valid_in(ldv),
    .load_dest_idx_in(ldi), .fr_n_data_in(frn), .fr_m_data_in(frm), .xfer_data_in(xf),
    .instr_ready_out(rdy), .busy_out(busy), .issue_out(iss), .op_out(), .src_sel_out(),
    .bank_sel_out(bks), .addr_mode_out(), .dst_idx_out(dix), .src_idx_out(six),
    .gpr_wr_out(gw), .addr_upd_out(au), .mem_rd_out(mr), .mem_wr_out(mw), .fr_wr_out(fw),
    .xfer_wr_out(xw), .fpu_start_out(fs), .t_wr_out(tw), .t_val_out(tv), .result_out(res),
    .trap_out(trp),
    .trap_code_out(tcode), .trap_cause_out(), .trap_vec_ofs_out(), .exc_priv_out(ep),
    .exc_illegal_out(ei));

  // ==========================================================
  // Shared tasks
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Hand one word over, then gather pulses, busy cycles and issue latency
  task automatic run(input logic [15:0] w, input logic p, output int lat, output int nb,
                     output logic [11:0] m);
    int k;
    lat = 0;
    nb = 0;
    m = 12'h000;
    @(negedge sys_clk);
    vld = 1'b1;
    ins = w;
    prv = p;
    for (k = 0; k < 50 && rdy !== 1'b1; k++) @(negedge sys_clk);
    if (k >= 50) begin
      num_errors++;
      wrap_up();
    end
    @(negedge sys_clk);
    vld = 1'b0;
    for (k = 1; k < 60; k++) begin
      m |= {1'b0, fs, xw, fw, gw, au, mr, mw, tw, trp, ep, ei};
      if (iss === 1'b1) lat = k;
      if (busy === 1'b1) nb++;
      if (rdy === 1'b1) break;
      @(negedge sys_clk);
    end
    if (k >= 60) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic one(input logic [15:0] w, input logic p, input int enb, input logic [11:0] em);
    int lat, nb;
    logic [11:0] m;
    run(w, p, lat, nb, m);
    chk({20'h0, m}, {20'h0, em});
    chk(nb, enb);
  endtask

  // ==========================================================
  // Scenarios
  task automatic sc_reset;
    chk({30'h0, rdy, busy}, 32'h0);
    @(negedge sys_clk);
    chk({30'h0, rdy, busy}, 32'h2);
  endtask

  task automatic sc_decode;
    one(16'h0382, 1'b1, 1, 12'h080);
    one(16'h0082, 1'b0, 0, 12'h002);
    one(16'h4103, 1'b1, 1, 12'h050);
    one(16'h4113, 1'b0, 1, 12'h050);
    one(16'h4223, 1'b0, 0, 12'h002);
    one(16'h4343, 1'b1, 1, 12'h050);
    one(16'h45F3, 1'b1, 2, 12'h050);
    chk({21'h0, bks, dix, six}, 32'h75F);
    one(16'h061A, 1'b0, 1, 12'h080);
    one(16'h072A, 1'b0, 1, 12'h080);
    one(16'h4802, 1'b0, 1, 12'h050);
    one(16'hC3A5, 1'b0, 6, 12'h004);
    chk({22'h0, tcode}, 32'h294);
    one(16'hF120, 1'b0, 1, 12'h400);
    one(16'hF121, 1'b0, 1, 12'h400);
    one(16'hF122, 1'b0, 1, 12'h400);
    one(16'hF123, 1'b0, 13, 12'h400);
    one(16'hF16D, 1'b0, 13, 12'h400);
    one(16'hF15D, 1'b0, 1, 12'h100);
    one(16'hF14D, 1'b0, 1, 12'h100);
    chk(res, 32'hBF80_0000);
    one(16'hF12E, 1'b0, 1, 12'h400);
    one(16'hF11D, 1'b0, 1, 12'h200);
    chk(res, 32'h3F80_0000);
    one(16'hF10D, 1'b0, 1, 12'h100);
    chk(res, 32'h0000_0007);
    one(16'hF12D, 1'b0, 1, 12'h400);
    one(16'hF13D, 1'b0, 1, 12'h400);
    one(16'hF128, 1'b0, 1, 12'h020);
    one(16'hF129, 1'b0, 1, 12'h060);
    one(16'hF126, 1'b0, 1, 12'h020);
    one(16'hF12A, 1'b0, 1, 12'h010);
    one(16'hF12B, 1'b0, 1, 12'h050);
    one(16'hF127, 1'b0, 1, 12'h010);
    one(16'hF12C, 1'b0, 1, 12'h100);
    chk(res, 32'h4000_0000);
    one(16'hF0FD, 1'b0, 0, 12'h001);
    one(16'h8000, 1'b1, 0, 12'h001);
  endtask

  task automatic sc_values;
    one(16'hF215, 1'b0, 1, 12'h008);
    chk({31'h0, tv}, 32'h1);
    one(16'hF125, 1'b0, 1, 12'h008);
    chk({31'h0, tv}, 32'h0);
    one(16'hF114, 1'b0, 1, 12'h008);
    chk({31'h0, tv}, 32'h1);
    one(16'hF19D, 1'b0, 1, 12'h100);
    chk(res, 32'h3F80_0000);
    one(16'hF18D, 1'b0, 1, 12'h100);
    chk(res, 32'h0000_0000);
  endtask

  task automatic sc_hazard;
    int lat, nb;
    logic [11:0] m;
    fc = 1'b1;
    fork
      run(16'hF120, 1'b0, lat, nb, m);
      begin
        repeat (4) @(negedge sys_clk);
        fc = 1'b0;
      end
    join
    chk({31'h0, lat > 1}, 32'h1);
    ldv = 1'b1;
    ldi = 4'h8;
    fork
      run(16'h4802, 1'b0, lat, nb, m);
      begin
        repeat (3) @(negedge sys_clk);
        ldv = 1'b0;
      end
    join
    chk({31'h0, lat > 1}, 32'h1);
    chk({20'h0, m}, 32'h50);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    vld = 1'b0;
    ins = 16'h0000;
    prv = 1'b0;
    fc = 1'b0;
    ldv = 1'b0;
    ldi = 4'h0;
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    sc_reset;
    sc_decode;
    sc_values;
    sc_hazard;
    wrap_up;
  end
endmodule

// [tb/sfd_fpr_model.sv]
// Floating register file and transfer register seen by the sequencer
`timescale 1ns/1ps
module sfd_fpr_model
(
  input  wire logic [15:0] instr_in,
  output logic [31:0]      fr_n_out,
  output logic [31:0]      fr_m_out,
  output logic [31:0]      xfer_out
);
  // Register one holds 1.0, register two 2.0, others distinct negatives
  function automatic logic [31:0] fr(input logic [3:0] i);
    return (i == 4'h1) ? 32'h3F80_0000 : (i == 4'h2) ? 32'h4000_0000 : {28'hC100_000, i};
  endfunction
  assign fr_n_out = fr(instr_in[11:8]);
  assign fr_m_out = fr(instr_in[7:4]);
  assign xfer_out = 32'h0000_0007;
endmodule

// [verilog/sfd_core.sv]
// Issue sequencer for system-control stores and single-precision instructions
`timescale 1ns/1ps

module sfd_core
  import sfd_pkg::*;
#(
  parameter bit DSP_VARIANT = 1'b0
)
(
  input  wire logic         sys_clk_in,
  input  wire logic         srst_in,
  input  wire logic         instr_valid_in,
  input  wire logic [15:0]  instr_in,
  input  wire logic         priv_mode_in,
  input  wire logic         fetch_contend_in,
  input  wire logic         load_dest_valid_in,
  input  wire logic [3:0]   load_dest_idx_in,
  input  wire logic [31:0]  fr_n_data_in,
  input  wire logic [31:0]  fr_m_data_in,
  input  wire logic [31:0]  xfer_data_in,
  output logic              instr_ready_out,
  output logic              busy_out,
  output logic              issue_out,
  output sfd_op_type        op_out,
  output sfd_src_type       src_sel_out,
  output logic [2:0]        bank_sel_out,
  output sfd_addr_type      addr_mode_out,
  output logic [3:0]        dst_idx_out,
  output logic [3:0]        src_idx_out,
  output logic              gpr_wr_out,
  output logic              addr_upd_out,
  output logic              mem_rd_out,
  output logic              mem_wr_out,
  output logic              fr_wr_out,
  output logic              xfer_wr_out,
  output logic              fpu_start_out,
  output logic              t_wr_out,
  output logic              t_val_out,
  output logic [31:0]       result_out,
  output logic              trap_out,
  output logic [9:0]        trap_code_out,
  output logic [11:0]       trap_cause_out,
  output logic [11:0]       trap_vec_ofs_out,
  output logic              exc_priv_out,
  output logic              exc_illegal_out
);

  // ==========================================================
  // State
  typedef struct packed {
    sfd_state_type st;
    logic [3:0]    cnt;
    sfd_op_type    op;
    sfd_src_type   src;
    logic [2:0]    bank;
    sfd_addr_type  am;
    logic [3:0]    rn;
    logic [3:0]    rm;
    logic [7:0]    imm;
    logic          ready;
    logic          busy;
    logic          issue;
    logic          gpr_wr;
    logic          addr_upd;
    logic          mem_rd;
    logic          mem_wr;
    logic          fr_wr;
    logic          xfer_wr;
    logic          fpu_start;
    logic          t_wr;
    logic          t_val;
    logic [31:0]   result;
    logic          trap;
    logic [9:0]    trap_code;
    logic [11:0]   cause;
    logic [11:0]   vec_ofs;
    logic          exc_priv;
    logic          exc_ill;
  } sfd_regs_type;

  sfd_regs_type s_r;
  sfd_regs_type s_nxt;

  // ==========================================================
  // Float helpers
  function automatic logic fp_nan(input logic [31:0] x);
    fp_nan = (x[30:23] == FP_EXP_MAX) && (x[22:0] != 23'h0);
  endfunction

  function automatic logic fp_eq(input logic [31:0] a, input logic [31:0] b);
    fp_eq = !fp_nan(a) && !fp_nan(b) &&
            ((a == b) || (a[30:0] == 31'h0 && b[30:0] == 31'h0));
  endfunction

  function automatic logic fp_gt(input logic [31:0] a, input logic [31:0] b);
    logic res;
    res = 1'b0;
    if (fp_nan(a) || fp_nan(b)) begin
      res = 1'b0;
    end else if (a[31] != b[31]) begin
      res = !a[31] && !(a[30:0] == 31'h0 && b[30:0] == 31'h0);
    end else if (!a[31]) begin
      res = a[30:0] > b[30:0];
    end else begin
      res = a[30:0] < b[30:0];
    end
    fp_gt = res;
  endfunction

  // ==========================================================
  // Decoder
  logic         dec_legal;
  logic         dec_priv;
  sfd_op_type   dec_op;
  sfd_src_type  dec_src;
  sfd_addr_type dec_am;
  logic [3:0]   dec_cycles;
  logic         dec_rd_n;
  logic         dec_rd_m;
  logic         dec_rd_r0;
  logic         hazard;
  logic         go;

  sfd_decode u_decode (
    .dsp_variant_in (DSP_VARIANT),
    .instr_in       (instr_in),
    .legal_out      (dec_legal),
    .priv_out       (dec_priv),
    .op_out         (dec_op),
    .src_out        (dec_src),
    .addr_out       (dec_am),
    .cycles_out     (dec_cycles),
    .rd_n_out       (dec_rd_n),
    .rd_m_out       (dec_rd_m),
    .rd_r0_out      (dec_rd_r0)
  );

  // Load-use match or fetch contention delays issue
  assign hazard = fetch_contend_in || (load_dest_valid_in &&
                  ((dec_rd_n && load_dest_idx_in == instr_in[11:8]) ||
                   (dec_rd_m && load_dest_idx_in == instr_in[7:4]) ||
                   (dec_rd_r0 && load_dest_idx_in == 4'h0)));

  // ==========================================================
  // Next state
  always_comb begin
    go              = 1'b0;
    s_nxt           = s_r;
    s_nxt.issue     = 1'b0;
    s_nxt.gpr_wr    = 1'b0;
    s_nxt.addr_upd  = 1'b0;
    s_nxt.mem_rd    = 1'b0;
    s_nxt.mem_wr    = 1'b0;
    s_nxt.fr_wr     = 1'b0;
    s_nxt.xfer_wr   = 1'b0;
    s_nxt.fpu_start = 1'b0;
    s_nxt.t_wr      = 1'b0;
    s_nxt.trap      = 1'b0;
    s_nxt.exc_priv  = 1'b0;
    s_nxt.exc_ill   = 1'b0;
    case (s_r.st)
      // Accept one instruction while ready
      ST_IDLE: begin
        if (instr_valid_in && s_r.ready) begin
          if (!dec_legal) begin
            s_nxt.exc_ill = 1'b1;
          end else if (dec_priv && !priv_mode_in) begin
            s_nxt.exc_priv = 1'b1;
          end else begin
            s_nxt.op   = dec_op;
            s_nxt.src  = dec_src;
            s_nxt.am   = dec_am;
            s_nxt.bank = instr_in[6:4];
            s_nxt.rn   = instr_in[11:8];
            s_nxt.rm   = instr_in[7:4];
            s_nxt.imm  = instr_in[7:0];
            s_nxt.cnt  = dec_cycles;
            if (hazard) begin
              s_nxt.st = ST_STALL;
            end else begin
              go = 1'b1;
            end
          end
        end
      end
      // Hold until data memory releases the fetch path
      ST_STALL: begin
        if (!fetch_contend_in) begin
          go = 1'b1;
        end
      end
      // Count minimum cycles, frozen under contention
      ST_EXEC: begin
        if (!fetch_contend_in) begin
          if (s_r.cnt <= CYC_ONE) begin
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.cnt = s_r.cnt - CYC_ONE;
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // Issue actions of the latched instruction
    if (go) begin
      s_nxt.st    = ST_EXEC;
      s_nxt.issue = 1'b1;
      case (s_nxt.op)
        OP_CR_STORE, OP_SYS_STORE: s_nxt.gpr_wr = 1'b1;
        OP_CR_PUSH, OP_SYS_PUSH: begin
          s_nxt.mem_wr   = 1'b1;
          s_nxt.addr_upd = 1'b1;
        end
        OP_TRAP: begin
          s_nxt.trap      = 1'b1;
          s_nxt.trap_code = {s_nxt.imm, 2'b00};
          s_nxt.cause     = TRAP_CAUSE;
          s_nxt.vec_ofs   = TRAP_VEC_OFS;
        end
        OP_FP_SUM, OP_FP_DIFF, OP_FP_MUL, OP_FP_QUOT, OP_FP_SQRT,
        OP_FP_MAC, OP_INT_TO_FP, OP_FP_TRUNC: begin
          s_nxt.fpu_start = 1'b1;
        end
        OP_FP_EQ: begin
          s_nxt.t_wr  = 1'b1;
          s_nxt.t_val = fp_eq(fr_n_data_in, fr_m_data_in);
        end
        OP_FP_GT: begin
          s_nxt.t_wr  = 1'b1;
          s_nxt.t_val = fp_gt(fr_n_data_in, fr_m_data_in);
        end
        OP_FP_MAG: begin
          s_nxt.fr_wr  = 1'b1;
          s_nxt.result = {1'b0, fr_n_data_in[30:0]};
        end
        OP_FP_NEG: begin
          s_nxt.fr_wr  = 1'b1;
          s_nxt.result = {~fr_n_data_in[31], fr_n_data_in[30:0]};
        end
        OP_FP_ZERO: begin
          s_nxt.fr_wr  = 1'b1;
          s_nxt.result = FP_ZERO;
        end
        OP_FP_ONE: begin
          s_nxt.fr_wr  = 1'b1;
          s_nxt.result = FP_ONE;
        end
        OP_FP_COPY: begin
          s_nxt.fr_wr  = 1'b1;
          s_nxt.result = fr_m_data_in;
        end
        OP_XFER_TO_FP: begin
          s_nxt.fr_wr  = 1'b1;
          s_nxt.result = xfer_data_in;
        end
        OP_FP_TO_XFER: begin
          s_nxt.xfer_wr = 1'b1;
          s_nxt.result  = fr_n_data_in;
        end
        OP_FP_LOAD: begin
          s_nxt.mem_rd   = 1'b1;
          s_nxt.addr_upd = s_nxt.am == AM_POSTINC;
        end
        OP_FP_STORE: begin
          s_nxt.mem_wr   = 1'b1;
          s_nxt.addr_upd = s_nxt.am == AM_PREDEC;
          s_nxt.result   = fr_m_data_in;
        end
        default: s_nxt.issue = 1'b0;
      endcase
    end
    s_nxt.ready = s_nxt.st == ST_IDLE;
    s_nxt.busy  = s_nxt.st != ST_IDLE;
  end

  // ==========================================================
  // Register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign instr_ready_out  = s_r.ready;
  assign busy_out         = s_r.busy;
  assign issue_out        = s_r.issue;
  assign op_out           = s_r.op;
  assign src_sel_out      = s_r.src;
  assign bank_sel_out     = s_r.bank;
  assign addr_mode_out    = s_r.am;
  assign dst_idx_out      = s_r.rn;
  assign src_idx_out      = s_r.rm;
  assign gpr_wr_out       = s_r.gpr_wr;
  assign addr_upd_out     = s_r.addr_upd;
  assign mem_rd_out       = s_r.mem_rd;
  assign mem_wr_out       = s_r.mem_wr;
  assign fr_wr_out        = s_r.fr_wr;
  assign xfer_wr_out      = s_r.xfer_wr;
  assign fpu_start_out    = s_r.fpu_start;
  assign t_wr_out         = s_r.t_wr;
  assign t_val_out        = s_r.t_val;
  assign result_out       = s_r.result;
  assign trap_out         = s_r.trap;
  assign trap_code_out    = s_r.trap_code;
  assign trap_cause_out   = s_r.cause;
  assign trap_vec_ofs_out = s_r.vec_ofs;
  assign exc_priv_out     = s_r.exc_priv;
  assign exc_illegal_out  = s_r.exc_ill;

endmodule

// [verilog/sfd_decode.sv]
// Combinational opcode decoder for the system-store and floating-point group
`timescale 1ns/1ps

module sfd_decode
  import sfd_pkg::*;
(
  input  wire logic         dsp_variant_in,
  input  wire logic [15:0]  instr_in,
  output logic              legal_out,
  output logic              priv_out,
  output sfd_op_type        op_out,
  output sfd_src_type       src_out,
  output sfd_addr_type      addr_out,
  output logic [3:0]        cycles_out,
  output logic              rd_n_out,
  output logic              rd_m_out,
  output logic              rd_r0_out
);

  // Control register select to source
  function automatic sfd_src_type cr_src(input logic [2:0] sel);
    case (sel)
      3'h0:    cr_src = SRC_STATUS;
      3'h1:    cr_src = SRC_GLOBAL;
      3'h2:    cr_src = SRC_VECTOR;
      3'h3:    cr_src = SRC_SAVED_SW;
      default: cr_src = SRC_SAVED_PC;
    endcase
  endfunction

  // System register select to source
  function automatic sfd_src_type sys_src(input logic [1:0] sel);
    case (sel)
      2'h0:    sys_src = SRC_ACC_HI;
      2'h1:    sys_src = SRC_ACC_LO;
      default: sys_src = SRC_LINK;
    endcase
  endfunction

  logic [3:0] low;
  logic [3:0] mid;

  assign low = instr_in[3:0];
  assign mid = instr_in[7:4];

  // ==========================================================
  // Decode
  always_comb begin
    legal_out  = 1'b0;
    priv_out   = 1'b0;
    op_out     = OP_NONE;
    src_out    = SRC_STATUS;
    addr_out   = AM_NONE;
    cycles_out = CYC_ONE;
    rd_n_out   = 1'b0;
    rd_m_out   = 1'b0;
    rd_r0_out  = 1'b0;
    case (instr_in[15:12])
      OPC_GRP_STORE: begin
        if (low == LOW_CR_STORE && (mid[3] || mid[2:0] <= CR_SEL_LAST)) begin
          legal_out = 1'b1;
          op_out    = OP_CR_STORE;
          src_out   = mid[3] ? SRC_BANK : cr_src(mid[2:0]);
          priv_out  = mid[3] || mid[2:0] != CR_SEL_GLOBAL;
        end else if (low == LOW_SYS_STORE && mid[3:2] == 2'h0 && mid[1:0] != SYS_SEL_BAD) begin
          legal_out = 1'b1;
          op_out    = OP_SYS_STORE;
          src_out   = sys_src(mid[1:0]);
        end
      end
      OPC_GRP_PUSH: begin
        rd_n_out = 1'b1;
        addr_out = AM_PREDEC;
        if (low == LOW_CR_PUSH && mid[3]) begin
          legal_out  = 1'b1;
          priv_out   = 1'b1;
          op_out     = OP_CR_PUSH;
          src_out    = SRC_BANK;
          cycles_out = CYC_BANK_PUSH;
        end else if (low == LOW_CR_PUSH && mid[2:0] <= CR_SEL_LAST) begin
          legal_out  = 1'b1;
          op_out     = OP_CR_PUSH;
          src_out    = cr_src(mid[2:0]);
          priv_out   = mid[2:0] != CR_SEL_GLOBAL;
          cycles_out = dsp_variant_in ? CYC_CR_PUSH_DSP : CYC_ONE;
        end else if (low == LOW_SYS_PUSH && mid[3:2] == 2'h0 && mid[1:0] != SYS_SEL_BAD) begin
          legal_out = 1'b1;
          op_out    = OP_SYS_PUSH;
          src_out   = sys_src(mid[1:0]);
        end
      end
      OPC_GRP_TRAP: begin
        if (instr_in[11:8] == OPC_TRAP_SUB) begin
          legal_out  = 1'b1;
          op_out     = OP_TRAP;
          cycles_out = dsp_variant_in ? CYC_TRAP_DSP : CYC_TRAP;
        end
      end
      OPC_GRP_FP: begin
        legal_out = 1'b1;
        case (low)
          4'h0: op_out = OP_FP_SUM;
          4'h1: op_out = OP_FP_DIFF;
          4'h2: op_out = OP_FP_MUL;
          4'h3: begin
            op_out     = OP_FP_QUOT;
            cycles_out = CYC_FP_LONG;
          end
          4'h4: op_out = OP_FP_EQ;
          4'h5: op_out = OP_FP_GT;
          4'h6: begin
            op_out    = OP_FP_LOAD;
            addr_out  = AM_R0_IDX;
            rd_m_out  = 1'b1;
            rd_r0_out = 1'b1;
          end
          4'h7: begin
            op_out    = OP_FP_STORE;
            addr_out  = AM_R0_IDX;
            rd_n_out  = 1'b1;
            rd_r0_out = 1'b1;
          end
          4'h8, 4'h9: begin
            op_out   = OP_FP_LOAD;
            addr_out = low[0] ? AM_POSTINC : AM_REG;
            rd_m_out = 1'b1;
          end
          4'hA, 4'hB: begin
            op_out   = OP_FP_STORE;
            addr_out = low[0] ? AM_PREDEC : AM_REG;
            rd_n_out = 1'b1;
          end
          4'hC: op_out = OP_FP_COPY;
          4'hD: begin
            case (mid)
              4'h0: op_out = OP_XFER_TO_FP;
              4'h1: op_out = OP_FP_TO_XFER;
              4'h2: op_out = OP_INT_TO_FP;
              4'h3: op_out = OP_FP_TRUNC;
              4'h4: op_out = OP_FP_NEG;
              4'h5: op_out = OP_FP_MAG;
              4'h6: begin
                op_out     = OP_FP_SQRT;
                cycles_out = CYC_FP_LONG;
              end
              4'h8: op_out = OP_FP_ZERO;
              4'h9: op_out = OP_FP_ONE;
              default: legal_out = 1'b0;
            endcase
          end
          4'hE: op_out = OP_FP_MAC;
          default: legal_out = 1'b0;
        endcase
      end
      default: legal_out = 1'b0;
    endcase
  end

endmodule

// [verilog/sfd_pkg.sv]
// Shared types and constants for the system-store and floating-point decoder
package sfd_pkg;

  // ==========================================================
  // Operation classes handed to the execution pipeline
  typedef enum logic [4:0] {
    OP_NONE       = 5'h00,
    OP_CR_STORE   = 5'h01,
    OP_CR_PUSH    = 5'h02,
    OP_SYS_STORE  = 5'h03,
    OP_SYS_PUSH   = 5'h04,
    OP_TRAP       = 5'h05,
    OP_FP_SUM     = 5'h06,
    OP_FP_DIFF    = 5'h07,
    OP_FP_MUL     = 5'h08,
    OP_FP_QUOT    = 5'h09,
    OP_FP_SQRT    = 5'h0A,
    OP_FP_EQ      = 5'h0B,
    OP_FP_GT      = 5'h0C,
    OP_FP_MAG     = 5'h0D,
    OP_FP_NEG     = 5'h0E,
    OP_FP_ZERO    = 5'h0F,
    OP_FP_ONE     = 5'h10,
    OP_FP_MAC     = 5'h11,
    OP_FP_TO_XFER = 5'h12,
    OP_XFER_TO_FP = 5'h13,
    OP_INT_TO_FP  = 5'h14,
    OP_FP_TRUNC   = 5'h15,
    OP_FP_COPY    = 5'h16,
    OP_FP_LOAD    = 5'h17,
    OP_FP_STORE   = 5'h18
  } sfd_op_type;

  // ==========================================================
  // Source register selection for stores and pushes
  typedef enum logic [3:0] {
    SRC_STATUS   = 4'h0,
    SRC_GLOBAL   = 4'h1,
    SRC_VECTOR   = 4'h2,
    SRC_SAVED_SW = 4'h3,
    SRC_SAVED_PC = 4'h4,
    SRC_BANK     = 4'h5,
    SRC_ACC_HI   = 4'h6,
    SRC_ACC_LO   = 4'h7,
    SRC_LINK     = 4'h8
  } sfd_src_type;

  // ==========================================================
  // Addressing modes of memory accesses
  typedef enum logic [2:0] {
    AM_NONE    = 3'h0,
    AM_REG     = 3'h1,
    AM_R0_IDX  = 3'h2,
    AM_POSTINC = 3'h3,
    AM_PREDEC  = 3'h4
  } sfd_addr_type;

  // ==========================================================
  // Sequencer states, Gray along idle, stall, execute
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_STALL = 2'h1,
    ST_EXEC  = 2'h3
  } sfd_state_type;

  // ==========================================================
  // Opcode fields
  localparam logic [3:0] OPC_GRP_STORE = 4'h0;
  localparam logic [3:0] OPC_GRP_PUSH  = 4'h4;
  localparam logic [3:0] OPC_GRP_TRAP  = 4'hC;
  localparam logic [3:0] OPC_TRAP_SUB  = 4'h3;
  localparam logic [3:0] OPC_GRP_FP    = 4'hF;
  localparam logic [3:0] LOW_CR_STORE  = 4'h2;
  localparam logic [3:0] LOW_SYS_STORE = 4'hA;
  localparam logic [3:0] LOW_CR_PUSH   = 4'h3;
  localparam logic [3:0] LOW_SYS_PUSH  = 4'h2;
  localparam logic [2:0] CR_SEL_GLOBAL = 3'h1;
  localparam logic [2:0] CR_SEL_LAST   = 3'h4;
  localparam logic [1:0] SYS_SEL_BAD   = 2'h3;

  // ==========================================================
  // Minimum execution cycles
  localparam logic [3:0] CYC_ONE          = 4'h1;
  localparam logic [3:0] CYC_CR_PUSH_DSP  = 4'h2;
  localparam logic [3:0] CYC_BANK_PUSH    = 4'h2;
  localparam logic [3:0] CYC_TRAP         = 4'h6;
  localparam logic [3:0] CYC_TRAP_DSP     = 4'h8;
  localparam logic [3:0] CYC_FP_LONG      = 4'hD;

  // ==========================================================
  // Trap and floating-point constants
  localparam logic [11:0] TRAP_CAUSE   = 12'h160;
  localparam logic [11:0] TRAP_VEC_OFS = 12'h100;
  localparam logic [31:0] FP_ZERO      = 32'h0000_0000;
  localparam logic [31:0] FP_ONE       = 32'h3F80_0000;
  localparam logic [7:0]  FP_EXP_MAX   = 8'hFF;

endpackage
